// ---- dct_params.svh ----
`ifndef DCT_PARAMS_SVH
`define DCT_PARAMS_SVH

// Bank that holds the counter/timer registers
`define DCT_BANK_D        4'hd

// Register offsets inside bank D
`define DCT_OFS_SCTRL     4'h0
`define DCT_OFS_LMODE     4'h1
`define DCT_OFS_LCTRL     4'h2
`define DCT_OFS_SLOW      4'h4
`define DCT_OFS_SHIGH     4'h5
`define DCT_OFS_LLOW      4'h6
`define DCT_OFS_LHIGH     4'h7
`define DCT_OFS_CAPL      4'h8
`define DCT_OFS_CAPH      4'h9

// Bit positions of the control registers; both share all but DCT_B_PINSEL, which only the long one holds
`define DCT_B_RUN         7
`define DCT_B_SINGLE      6
`define DCT_B_TIMEOUT     5
`define DCT_B_PRE_HI      4
`define DCT_B_PRE_LO      3
`define DCT_B_CAPMASK     2
`define DCT_B_TOMASK      1
`define DCT_B_PINSEL      0

// Bit positions of the long counter mode register
`define DCT_B_INITLVL     0
`define DCT_B_DEMOD       1
`define DCT_B_FIRSTONLY   2
`define DCT_B_CAPFLAG     7

// Reset values and register masks
`define DCT_RST_CTRL      8'h00
`define DCT_RST_DATA      8'h00
`define DCT_CTRL_RD_MASK  8'hfe
`define DCT_LMODE_MASK    8'h87

`endif

// ---- dct_pkg.sv ----
package dct_pkg;

	typedef enum logic [1:0] {
		DCT_DIV1 = 2'b00,
		DCT_DIV2 = 2'b01,
		DCT_DIV4 = 2'b10,
		DCT_DIV8 = 2'b11
	} dct_presc_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] bank;
		logic [3:0] addr;
		logic [7:0] wdata;
	} dct_req_t;

	typedef struct packed {
		logic [7:0]  s_ctrl;
		logic [7:0]  s_low;
		logic [7:0]  s_high;
		logic [7:0]  s_cnt;
		logic [7:0]  l_ctrl;
		logic [7:0]  l_mode;
		logic [7:0]  l_low;
		logic [7:0]  l_high;
		logic [15:0] l_cnt;
		logic [15:0] l_cap;
		logic        l_out;
		logic        l_seen;
		logic [2:0]  pre;
		logic [2:0]  sync;
		logic [7:0]  rdata;
		logic        pin;
		logic        s_to_irq;
		logic        s_cap_irq;
		logic        l_to_irq;
		logic        l_cap_irq;
	} dct_state_t;

endpackage

// ---- dct_counter_timer.sv ----
`include "dct_params.svh"

module dct_counter_timer
	import dct_pkg::*;
(
	input  wire logic     clock,
	input  wire logic     rst,
	input  wire dct_req_t req,
	input  wire logic     demod_in,
	input  wire logic     port_data_bit,
	input  wire logic     short_capture_event,
	output logic [7:0]    rdata,
	output logic          port3_bit5_pin,
	output logic          short_timeout_irq,
	output logic          short_capture_irq,
	output logic          long_timeout_irq,
	output logic          long_capture_irq
);

	dct_state_t q;
	dct_state_t d;

	logic       hit_wr;
	logic       hit_rd;
	logic       s_tick;
	logic       l_tick;
	logic       edge_seen;
	logic       s_start;
	logic       l_start;
	logic       l_load_cap;
	logic [7:0] rd_mux;

	function automatic logic presc_tick(input logic [1:0] sel, input logic [2:0] cnt);
		logic t;
		t = 1'b0;
		case (dct_presc_t'(sel))
			DCT_DIV1: t = 1'b1;
			DCT_DIV2: t = cnt[0];
			DCT_DIV4: t = &cnt[1:0];
			DCT_DIV8: t = &cnt;
			default:  t = 1'b0;
		endcase
		return t;
	endfunction

	// bank select
	// The processor only reaches us while the pointer names bank D
	assign hit_wr = req.wr && (req.bank == `DCT_BANK_D);
	assign hit_rd = req.rd && (req.bank == `DCT_BANK_D);

	assign s_tick = presc_tick(q.s_ctrl[`DCT_B_PRE_HI:`DCT_B_PRE_LO], q.pre);
	assign l_tick = presc_tick(q.l_ctrl[`DCT_B_PRE_HI:`DCT_B_PRE_LO], q.pre);

	// Edge detector reads only the second and third sync stages
	assign edge_seen = q.sync[1] ^ q.sync[2];

	assign s_start = hit_wr && (req.addr == `DCT_OFS_SCTRL)
		&& req.wdata[`DCT_B_RUN] && !q.s_ctrl[`DCT_B_RUN];
	assign l_start = hit_wr && (req.addr == `DCT_OFS_LCTRL)
		&& req.wdata[`DCT_B_RUN] && !q.l_ctrl[`DCT_B_RUN];

	assign l_load_cap = q.l_ctrl[`DCT_B_RUN] && q.l_mode[`DCT_B_DEMOD] && edge_seen
		&& !(q.l_mode[`DCT_B_FIRSTONLY] && q.l_seen);

	always_comb begin
		rd_mux = 8'h00;
		case (req.addr)
			`DCT_OFS_SCTRL: rd_mux = q.s_ctrl & `DCT_CTRL_RD_MASK;
			`DCT_OFS_LMODE: rd_mux = q.l_mode;
			`DCT_OFS_LCTRL: rd_mux = q.l_ctrl;
			`DCT_OFS_SLOW:  rd_mux = q.s_low;
			`DCT_OFS_SHIGH: rd_mux = q.s_high;
			`DCT_OFS_LLOW:  rd_mux = q.l_low;
			`DCT_OFS_LHIGH: rd_mux = q.l_high;
			`DCT_OFS_CAPL:  rd_mux = q.l_cap[7:0];
			`DCT_OFS_CAPH:  rd_mux = q.l_cap[15:8];
			default:        rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		d = q;
		d.s_to_irq  = 1'b0;
		d.s_cap_irq = 1'b0;
		d.l_to_irq  = 1'b0;
		d.l_cap_irq = 1'b0;
		d.pre  = q.pre + 3'h1;
		d.sync = {q.sync[1:0], demod_in};
		if (hit_rd) begin
			d.rdata = rd_mux;
		end

		// Register writes; flags are write-one-to-clear and set later wins
		if (hit_wr) begin
			case (req.addr)
				`DCT_OFS_SCTRL: begin
					d.s_ctrl = {req.wdata[7:6],
						q.s_ctrl[`DCT_B_TIMEOUT] & ~req.wdata[`DCT_B_TIMEOUT],
						req.wdata[4:1], 1'b0};
				end
				`DCT_OFS_LCTRL: begin
					d.l_ctrl = {req.wdata[7:6],
						q.l_ctrl[`DCT_B_TIMEOUT] & ~req.wdata[`DCT_B_TIMEOUT],
						req.wdata[4:0]};
				end
				`DCT_OFS_LMODE: begin
					d.l_mode = (req.wdata & 8'h07)
						| {q.l_mode[`DCT_B_CAPFLAG] & ~req.wdata[`DCT_B_CAPFLAG], 7'h00};
				end
				`DCT_OFS_SLOW:  d.s_low = req.wdata;
				`DCT_OFS_SHIGH: d.s_high = req.wdata;
				`DCT_OFS_LLOW:  d.l_low = req.wdata;
				`DCT_OFS_LHIGH: d.l_high = req.wdata;
				default: begin
				end
			endcase
		end

		// Short counter
		if (s_start) begin
			d.s_cnt = q.s_low;
		end else if (q.s_ctrl[`DCT_B_RUN] && s_tick) begin
			if (q.s_cnt == 8'h00) begin
				d.s_ctrl[`DCT_B_TIMEOUT] = 1'b1;
				d.s_to_irq = q.s_ctrl[`DCT_B_TOMASK];
				if (q.s_ctrl[`DCT_B_SINGLE]) begin
					d.s_ctrl[`DCT_B_RUN] = 1'b0;
				end else begin
					d.s_cnt = q.s_low;
				end
			end else begin
				d.s_cnt = q.s_cnt - 8'h01;
			end
		end

		d.s_cap_irq = short_capture_event && q.s_ctrl[`DCT_B_CAPMASK];

		// Long counter
		if (l_start) begin
			d.l_cnt  = {q.l_high, q.l_low};
			d.l_out  = q.l_mode[`DCT_B_INITLVL];
			d.l_seen = 1'b0;
		end else if (l_load_cap) begin
			d.l_cap  = q.l_cnt;
			d.l_cnt  = {q.l_high, q.l_low};
			d.l_seen = 1'b1;
			d.l_mode[`DCT_B_CAPFLAG] = 1'b1;
			d.l_cap_irq = q.l_ctrl[`DCT_B_CAPMASK];
		end else if (q.l_ctrl[`DCT_B_RUN] && l_tick) begin
			if (q.l_cnt == 16'h0000) begin
				d.l_ctrl[`DCT_B_TIMEOUT] = 1'b1;
				d.l_out = ~q.l_out;
				d.l_to_irq = q.l_ctrl[`DCT_B_TOMASK];
				if (q.l_ctrl[`DCT_B_SINGLE]) begin
					d.l_ctrl[`DCT_B_RUN] = 1'b0;
				end else begin
					d.l_cnt = {q.l_high, q.l_low};
				end
			end else begin
				d.l_cnt = q.l_cnt - 16'h0001;
			end
		end else if (!q.l_ctrl[`DCT_B_RUN]) begin
			// Idle level is the complement of the start level
			d.l_out = ~q.l_mode[`DCT_B_INITLVL];
		end

		d.pin = q.l_ctrl[`DCT_B_PINSEL] ? d.l_out : port_data_bit;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata             = q.rdata;
	assign port3_bit5_pin    = q.pin;
	assign short_timeout_irq = q.s_to_irq;
	assign short_capture_irq = q.s_cap_irq;
	assign long_timeout_irq  = q.l_to_irq;
	assign long_capture_irq  = q.l_cap_irq;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// Short counter: run control, count path and flags
	a_short_run_start: assert property (
		hit_wr && req.addr == `DCT_OFS_SCTRL && req.wdata[7] && !q.s_ctrl[7]
		|=> q.s_ctrl[7] && q.s_cnt == $past(q.s_low))
		else $error("short counter did not start");
	a_short_run_stop: assert property (
		hit_wr && req.addr == `DCT_OFS_SCTRL && !req.wdata[7] |=> !q.s_ctrl[7])
		else $error("short counter did not stop");
	a_short_single_stop: assert property (
		q.s_ctrl[7] && q.s_ctrl[6] && s_tick && q.s_cnt == 8'h00 && !hit_wr
		|=> !q.s_ctrl[7] && q.s_ctrl[5])
		else $error("single pass did not stop");
	a_short_modulo_run: assert property (
		q.s_ctrl[7] && !q.s_ctrl[6] && s_tick && q.s_cnt == 8'h00 && !hit_wr
		|=> q.s_ctrl[7] && q.s_cnt == $past(q.s_low))
		else $error("modulo did not reload");
	a_short_div8_rate: assert property (
		q.s_ctrl[4:3] == 2'b11 && q.pre != 3'h7 |-> !s_tick)
		else $error("divide by eight ticked early");
	a_short_div1_rate: assert property (
		q.s_ctrl[4:3] == 2'b00 |-> s_tick)
		else $error("undivided clock missed a tick");
	a_short_cap_gate: assert property (
		short_capture_irq == $past(short_capture_event && q.s_ctrl[2]))
		else $error("short capture irq gate wrong");
	a_short_flag_set: assert property (
		q.s_ctrl[7] && s_tick && q.s_cnt == 8'h00 |=> q.s_ctrl[5])
		else $error("short flag not set");
	// A clear that meets a set in one cycle loses, so it is only checked alone
	a_short_flag_clear: assert property (
		hit_wr && req.addr == `DCT_OFS_SCTRL && req.wdata[5]
		&& !(q.s_ctrl[7] && s_tick && q.s_cnt == 8'h00) |=> !q.s_ctrl[5])
		else $error("short flag not cleared");

	// Long counter: capture, flags, interrupts and pin
	a_long_edge_capture: assert property (
		q.l_ctrl[7] && q.l_mode[1] && !q.l_mode[2] && edge_seen && !l_start
		|=> q.l_cap == $past(q.l_cnt) && q.l_cnt == $past({q.l_high, q.l_low}))
		else $error("edge not captured");

	a_long_first_only: assert property (
		q.l_mode[1] && q.l_mode[2] && q.l_seen && !l_start
		|=> q.l_cap == $past(q.l_cap))
		else $error("later edge captured");

	a_long_flag_set: assert property (
		q.l_ctrl[7] && l_tick && q.l_cnt == 16'h0000 && !l_start && !l_load_cap
		|=> q.l_ctrl[5])
		else $error("long flag not set");

	// Only checked while stopped, where no terminal count can set the flag again
	a_long_flag_clear: assert property (
		hit_wr && req.addr == `DCT_OFS_LCTRL && req.wdata[5] && !q.l_ctrl[7]
		|=> !q.l_ctrl[5])
		else $error("long flag not cleared");

	a_long_div8_rate: assert property (
		q.l_ctrl[4:3] == 2'b11 && q.pre != 3'h7 |-> !l_tick)
		else $error("long divide by eight ticked early");

	a_long_capture_irq: assert property (
		long_capture_irq == $past(l_load_cap && !l_start && q.l_ctrl[2]))
		else $error("long capture irq gate wrong");

	a_long_timeout_irq: assert property (
		long_timeout_irq == $past(q.l_ctrl[7] && l_tick && q.l_cnt == 16'h0000
			&& !l_start && !l_load_cap && q.l_ctrl[1]))
		else $error("long time-out irq gate wrong");

	a_pin_select: assert property (
		!q.l_ctrl[0] && !$past(q.l_ctrl[0])
		|=> port3_bit5_pin == $past(port_data_bit))
		else $error("pin not on port data");

	a_pin_long: assert property (
		q.l_ctrl[0] && $past(q.l_ctrl[0])
		|-> port3_bit5_pin == q.l_out)
		else $error("pin not on long output");

	a_long_toggle_out: assert property (
		q.l_ctrl[7] && l_tick && q.l_cnt == 16'h0000 && !l_start && !l_load_cap
		|=> q.l_out != $past(q.l_out) && long_timeout_irq == $past(q.l_ctrl[1]))
		else $error("long zero actions wrong");

	a_long_modulo_reload: assert property (
		q.l_ctrl[7] && !q.l_ctrl[6] && l_tick && q.l_cnt == 16'h0000
		&& !l_start && !l_load_cap && !hit_wr
		|=> q.l_ctrl[7] && q.l_cnt == $past({q.l_high, q.l_low}))
		else $error("long modulo did not reload");

	a_long_single_stop: assert property (
		q.l_ctrl[7] && q.l_ctrl[6] && l_tick && q.l_cnt == 16'h0000
		&& !l_start && !l_load_cap && !hit_wr
		|=> !q.l_ctrl[7])
		else $error("long single pass did not stop");

	// Register file: holds, bank guard and read port
	a_long_low_hold: assert property (
		hit_wr && req.addr == `DCT_OFS_LLOW |=> q.l_low == $past(req.wdata))
		else $error("long low hold not written");
	a_short_high_hold: assert property (
		hit_wr && req.addr == `DCT_OFS_SHIGH |=> q.s_high == $past(req.wdata))
		else $error("short high hold not written");
	a_short_low_hold: assert property (
		hit_wr && req.addr == `DCT_OFS_SLOW |=> q.s_low == $past(req.wdata))
		else $error("short low hold not written");
	a_bank_guard: assert property (
		req.wr && req.bank != `DCT_BANK_D |=> q.s_low == $past(q.s_low) && q.l_low == $past(q.l_low))
		else $error("write outside bank reached a hold");
	a_read_data: assert property (
		hit_rd |=> rdata == $past(rd_mux))
		else $error("read data not registered");
	// Software may poll rdata long after the read, so it must not drift
	a_read_hold: assert property (
		!hit_rd |=> rdata == $past(rdata))
		else $error("read data changed without a read");

	// Main scenarios the bench should reach
	c_short_timeout: cover property (short_timeout_irq);
	c_long_capture: cover property (long_capture_irq ##[1:50] long_capture_irq);
	c_long_single: cover property (q.l_ctrl[7] && q.l_ctrl[6] ##1 !q.l_ctrl[7]);
	c_short_modulo: cover property (short_timeout_irq ##[1:100] short_timeout_irq);
	c_pin_long_high: cover property (q.l_ctrl[0] && port3_bit5_pin);

endmodule

// ---- dual_counter_timer_control_tb_top.sv ----
module dual_counter_timer_control_tb_top import dct_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [3:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} dct_row_t;
	logic       clock = 0, rst = 1, demod_in = 0, port_data_bit = 0, short_capture_event = 0;
	dct_req_t   req = '0;
	logic [7:0] rdata, q;
	logic       pin, sto, sci, lto, lci;
	int         err_total = 0, samples_checked = 0, n, m, k, sci_n = 0, lci_n = 0;
	dct_row_t   rows [6] = '{'{4'h4, 8'ha5, 8'ha5}, '{4'h5, 8'h5a, 8'h5a},
		'{4'h6, 8'hc3, 8'hc3}, '{4'h7, 8'h3c, 8'h3c}, '{4'hc, 8'h77, 8'h00},
		'{4'h3, 8'hff, 8'h00}};
	dct_counter_timer dut (.clock(clock), .rst(rst), .req(req), .demod_in(demod_in),
		.port_data_bit(port_data_bit), .short_capture_event(short_capture_event),
		.rdata(rdata), .port3_bit5_pin(pin), .short_timeout_irq(sto),
		.short_capture_irq(sci), .long_timeout_irq(lto), .long_capture_irq(lci));
	always #25 clock = ~clock;
	// Pulses are registered, so count them away from the rising edge
	always @(negedge clock) begin
		sci_n += sci;
		lci_n += lci;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Read data lands one edge after the strobe edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
			input logic [3:0] b = 4'hd);
		@(posedge clock);
		req <= '{wr: w, rd: !w, bank: b, addr: a, wdata: d};
		@(posedge clock);
		req <= '0;
		#1 q = rdata;
	endtask
	// Bounded wait for a time-out pulse; c reaches 300 when none comes
	task automatic wp(input bit lng, output int c);
		c = 0;
		do begin
			@(posedge clock);
			#1 c++;
		end while ((lng ? lto : sto) !== 1'b1 && c < 300);
	endtask
	task automatic pulse_sce;
		@(posedge clock);
		short_capture_event <= 1;
		@(posedge clock);
		short_capture_event <= 0;
		repeat (4) @(posedge clock);
	endtask
	initial begin
		#(50 * 8000);
		err_total++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 0;
		bus(0, 4'h0, 8'h00);
		chk(q, 8'h00);
		foreach (rows[i]) begin
			bus(1, rows[i].a, rows[i].d);
			bus(0, rows[i].a, 8'h00);
			chk(q, rows[i].e);
		end
		bus(1, 4'h4, 8'h11, 4'h0);
		bus(0, 4'h4, 8'h00);
		chk(q, 8'ha5);
		$display("register table done");
		bus(1, 4'h4, 8'h03);
		bus(1, 4'h0, 8'hc0);
		repeat (20) @(posedge clock);
		bus(0, 4'h0, 8'h00);
		chk(q & 8'he0, 8'h60);
		bus(1, 4'h0, 8'h40);
		bus(0, 4'h0, 8'h00);
		chk(q & 8'he0, 8'h60);
		bus(1, 4'h0, 8'h20);
		bus(0, 4'h0, 8'h00);
		chk(q & 8'he0, 8'h00);
		bus(1, 4'h4, 8'h06);
		for (int p = 0; p < 4; p++) begin
			bus(1, 4'h0, 8'h82 | 8'(p << 3));
			wp(0, n);
			wp(0, m);
			chk({7'h0, m == (6 << p) || m == (7 << p)}, 8'h01);
			bus(0, 4'h0, 8'h00);
			chk(q & 8'h98, 8'h80 | 8'(p << 3));
		end
		bus(1, 4'h0, 8'h80);
		wp(0, n);
		chk({7'h0, n >= 300}, 8'h01);
		bus(1, 4'h0, 8'h24);
		k = sci_n;
		pulse_sce();
		bus(1, 4'h0, 8'h00);
		pulse_sce();
		chk(8'(sci_n - k), 8'h01);
		$display("short counter done");
		bus(1, 4'h6, 8'h05);
		bus(1, 4'h7, 8'h00);
		bus(1, 4'h1, 8'h00);
		bus(1, 4'h2, 8'hc3);
		repeat (2) @(posedge clock);
		#1 chk({7'h0, pin}, 8'h00);
		wp(1, n);
		chk({7'h0, n < 300}, 8'h01);
		repeat (3) @(posedge clock);
		#1 chk({7'h0, pin}, 8'h01);
		bus(0, 4'h2, 8'h00);
		chk(q & 8'he0, 8'h60);
		bus(1, 4'h2, 8'h20);
		bus(0, 4'h2, 8'h00);
		chk(q & 8'he0, 8'h00);
		@(posedge clock);
		port_data_bit <= 1;
		repeat (3) @(posedge clock);
		#1 chk({7'h0, pin}, 8'h01);
		@(posedge clock);
		port_data_bit <= 0;
		repeat (3) @(posedge clock);
		#1 chk({7'h0, pin}, 8'h00);
		for (int p = 0; p < 4; p++) begin
			bus(1, 4'h2, 8'h82 | 8'(p << 3));
			wp(1, n);
			wp(1, m);
			chk({7'h0, m == (5 << p) || m == (6 << p)}, 8'h01);
		end
		bus(1, 4'h2, 8'h20);
		$display("long counter done");
		bus(1, 4'h6, 8'h00);
		bus(1, 4'h7, 8'h01);
		for (int j = 0; j < 3; j++) begin
			bus(1, 4'h1, j == 1 ? 8'h06 : 8'h02);
			bus(1, 4'h2, j == 2 ? 8'h80 : 8'h84);
			k = lci_n;
			repeat (2) begin
				@(posedge clock);
				demod_in <= ~demod_in;
				repeat (10) @(posedge clock);
			end
			bus(0, 4'h1, 8'h00);
			chk(q & 8'h80, 8'h80);
			chk(8'(lci_n - k), 8'(2 >> j));
			bus(0, 4'h9, 8'h00);
			chk(q, 8'h00);
			bus(1, 4'h2, 8'h20);
			bus(1, 4'h1, 8'h80);
		end
		$display("demodulation done");
		bus(1, 4'h0, 8'h80);
		@(posedge clock);
		rst <= 1;
		repeat (2) @(posedge clock);
		rst <= 0;
		bus(0, 4'h0, 8'h00);
		chk(q, 8'h00);
		$display("mid-run reset done");
		end_sim;
	end
endmodule
